// file: core/ldc_pkg.sv
// ldc_pkg: constants shared by the led dimming control block
// assumes a 25 MHz core clock; times are converted to cycle counts here
package ldc_pkg;

  // core clock rate in hertz
  localparam int unsigned CLK_HZ = 25_000_000;

  // documented times, figures as printed
  localparam int unsigned PROG_LOW_MIN_NS = 200;
  localparam int unsigned PROG_LOW_MAX_US = 100;
  localparam int unsigned SLEEP_LOW_US = 1500;
  localparam int unsigned STEP_UP_DELAY_US = 400;
  localparam int unsigned SETTLE_US = 40;

  // least times round up, longest round down, never below one cycle
  localparam int unsigned PROG_LOW_MIN_CYC =
    (PROG_LOW_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PROG_LOW_MAX_CYC =
    PROG_LOW_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SLEEP_LOW_CYC = SLEEP_LOW_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STEP_UP_CYC =
    STEP_UP_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);

  // width of the shared time counters
  localparam int unsigned CNT_W = 16;

  // gain codes: level index 0..5 is 132 shifted right by the index
  localparam logic [2:0] LEVEL_FULL = 3'h0;
  localparam logic [2:0] LEVEL_LAST = 3'h5;

  // pump mode codes on the pump mode output
  localparam logic [1:0] PUMP_1X = 2'h0;
  localparam logic [1:0] PUMP_1X33 = 2'h1;
  localparam logic [1:0] PUMP_1X5 = 2'h2;
  localparam logic [1:0] PUMP_2X = 2'h3;

endpackage

// file: core/ldc_sync.sv
// ldc_sync: three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk_in; output changes once
// the second and third stages agree on a new level
`timescale 1ns/1ns
module ldc_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // raw pin and filtered level
  input wire logic pin_in,
  output logic level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } ldc_sync_s;

  ldc_sync_s st_q;
  ldc_sync_s st_d;

  // shift chain; first stage read only by the second
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s3;
    end
  end

  // register the state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;

endmodule

// file: core/ldc_top.sv
// ldc_top: one-wire enable and dimming control with pump mode sequencing
// assumes analog comparators give clean same-clock-free status levels,
// each passed through a synchroniser here; one 25 MHz clock
//
// Behaviour
// - first rise from shutdown enables device at full-scale gain 132.
// - each later rising edge halves led current down to 3.125 percent.
// - gain steps 132,66,33,16.5,8.25,4.125 then wraps back to 132.
// - input low for 1.5 ms or longer enters zero-current shutdown.
// - low pulses shorter than 0.2 us are filtered and ignored.
// - low pulses longer than 100 us may count as shutdown request.
// - led current settles to a new level within typical 40 us.
// - undervoltage indication disables all channels and forces shutdown.
// - shutdown puts led outputs high impedance and releases set pin.
// - pump starts in 1x and stays while enabled channels regulate.
// - loss of regulation steps pump up only after about 400 us.
// - step-up order is 1.33x, 1.5x, 2x, each with the same delay.
// - never step down to intermediate mode; return straight to 1x.
// - open led channel is excluded from regulation and step-up decision.
// - all channels open forces the pump into 1x mode.
// - output overvoltage forces the pump to 1x and re-evaluates mode from 1x.
// - over-temperature enters thermal shutdown, resumes when cooled.
// - in 1x mode pump switches stay idle, linear operation only.
`timescale 1ns/1ns
module ldc_top #(
  parameter int unsigned SLEEP_CYC = ldc_pkg::SLEEP_LOW_CYC,
  parameter int unsigned STEP_CYC = ldc_pkg::STEP_UP_CYC,
  parameter int unsigned NUM_CH = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // one-wire enable and dimming pin
  input wire logic enable_dim_input_in,
  // analog status indications
  input wire logic undervoltage_in,
  input wire logic overvoltage_in,
  input wire logic over_temp_in,
  input wire logic unity_mode_ok_in,
  input wire logic [NUM_CH-1:0] led_open_in,
  input wire logic [NUM_CH-1:0] led_low_headroom_in,
  // led channel and set pin control
  output logic [NUM_CH-1:0] led_channel_enable_out,
  output logic current_set_pin_enable_out,
  output logic [2:0] gain_level_out,
  output logic current_settled_out,
  // pump control
  output logic [1:0] pump_mode_out,
  output logic pump_switch_enable_out,
  // state
  output logic active_out
);

  //////////////////////////////////////////////////////////////////////////
  // synchronised inputs

  logic pin_lvl;
  logic uv_lvl;
  logic ov_lvl;
  logic ot_lvl;
  logic ok1x_lvl;
  logic [NUM_CH-1:0] open_lvl;
  logic [NUM_CH-1:0] head_lvl;

  // pin passes three stages with agreement filter
  ldc_sync u_pin (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .pin_in(enable_dim_input_in), .level_out(pin_lvl)
  );
  ldc_sync u_uv (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .pin_in(undervoltage_in), .level_out(uv_lvl)
  );
  ldc_sync u_ov (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .pin_in(overvoltage_in), .level_out(ov_lvl)
  );
  ldc_sync u_ot (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .pin_in(over_temp_in), .level_out(ot_lvl)
  );
  ldc_sync u_ok (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .pin_in(unity_mode_ok_in), .level_out(ok1x_lvl)
  );

  // per-channel status synchronisers
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    ldc_sync u_open (
      .clk_in(clk_in), .reset_n_in(reset_n_in),
      .pin_in(led_open_in[i]), .level_out(open_lvl[i])
    );
    ldc_sync u_head (
      .clk_in(clk_in), .reset_n_in(reset_n_in),
      .pin_in(led_low_headroom_in[i]), .level_out(head_lvl[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [2:0] {
    LDC_OFF = 3'b001,
    LDC_ON = 3'b010,
    LDC_LOW = 3'b100
  } ldc_link_e;

  typedef struct packed {
    ldc_link_e link;
    logic [ldc_pkg::CNT_W-1:0] low_cnt;
    logic [2:0] level;
    logic [ldc_pkg::CNT_W-1:0] step_cnt;
    logic [ldc_pkg::CNT_W-1:0] settle_cnt;
    logic [1:0] pump;
    logic [NUM_CH-1:0] led_en;
    logic current_set_pin_en;
    logic sw_en;
    logic settled;
    logic active;
  } ldc_s;

  ldc_s st_q;
  ldc_s st_d;

  // next level index with wrap after the sixth level
  function automatic logic [2:0] ldc_next_level(input logic [2:0] lvl);
    if (lvl >= ldc_pkg::LEVEL_LAST) begin
      ldc_next_level = ldc_pkg::LEVEL_FULL;
    end else begin
      ldc_next_level = 3'(lvl + 3'h1);
    end
  endfunction

  // a pending step-up needs a regulating channel that lacks headroom
  logic [NUM_CH-1:0] used_ch;
  logic need_step;
  logic all_open;
  logic fault;

  always_comb begin
    used_ch = ~open_lvl;
    need_step = |(head_lvl & used_ch);
    all_open = &open_lvl;
    fault = uv_lvl | ot_lvl;
  end

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    // link: enable, dimming edges and shutdown timeout
    case (st_q.link)
      LDC_OFF: begin
        st_d.low_cnt = '0;
        st_d.level = ldc_pkg::LEVEL_FULL;
        if (pin_lvl && !fault) begin
          st_d.link = LDC_ON;
          st_d.level = ldc_pkg::LEVEL_FULL;
        end
      end
      LDC_ON: begin
        st_d.low_cnt = '0;
        if (!pin_lvl) begin
          st_d.link = LDC_LOW;
          st_d.low_cnt = ldc_pkg::CNT_W'(1);
        end
      end
      LDC_LOW: begin
        if (pin_lvl) begin
          st_d.link = LDC_ON;
          // short glitch leaves the level unchanged
          if (st_q.low_cnt >= ldc_pkg::CNT_W'(ldc_pkg::PROG_LOW_MIN_CYC)) begin
            st_d.level = ldc_next_level(st_q.level);
          end
        end else if (st_q.low_cnt >= ldc_pkg::CNT_W'(SLEEP_CYC - 1)) begin
          st_d.link = LDC_OFF;
        end else begin
          st_d.low_cnt = ldc_pkg::CNT_W'(st_q.low_cnt + 1'b1);
        end
      end
      default: begin
        st_d.link = LDC_OFF;
      end
    endcase

    // undervoltage or over-temperature forces shutdown
    if (fault) begin
      st_d.link = LDC_OFF;
      st_d.level = ldc_pkg::LEVEL_FULL;
    end

    // settle timer restarts on any level change or enable
    if (st_d.level != st_q.level || st_d.link == LDC_OFF) begin
      st_d.settle_cnt = '0;
      st_d.settled = 1'b0;
    end else if (st_q.settle_cnt >= ldc_pkg::CNT_W'(ldc_pkg::SETTLE_CYC - 1))
    begin
      st_d.settled = 1'b1;
    end else begin
      st_d.settle_cnt = ldc_pkg::CNT_W'(st_q.settle_cnt + 1'b1);
    end

    // pump mode sequencing
    if (st_d.link == LDC_OFF || ov_lvl || all_open) begin
      st_d.pump = ldc_pkg::PUMP_1X;
      st_d.step_cnt = '0;
    end else if (st_q.pump != ldc_pkg::PUMP_1X && ok1x_lvl) begin
      st_d.pump = ldc_pkg::PUMP_1X;
      st_d.step_cnt = '0;
    end else if (need_step && st_q.pump != ldc_pkg::PUMP_2X) begin
      if (st_q.step_cnt >= ldc_pkg::CNT_W'(STEP_CYC - 1)) begin
        st_d.pump = 2'(st_q.pump + 2'h1);
        st_d.step_cnt = '0;
      end else begin
        st_d.step_cnt = ldc_pkg::CNT_W'(st_q.step_cnt + 1'b1);
      end
    end else begin
      st_d.step_cnt = '0;
    end

    // outputs follow the next state so they leave flip-flops directly
    st_d.active = (st_d.link != LDC_OFF);
    st_d.led_en = st_d.active ? used_ch : '0;
    st_d.current_set_pin_en = st_d.active;
    st_d.sw_en = st_d.active && (st_d.pump != ldc_pkg::PUMP_1X);
  end

  // register the state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_q <= '{link: LDC_OFF, pump: ldc_pkg::PUMP_1X, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign led_channel_enable_out = st_q.led_en;
  assign current_set_pin_enable_out = st_q.current_set_pin_en;
  assign gain_level_out = st_q.level;
  assign current_settled_out = st_q.settled;
  assign pump_mode_out = st_q.pump;
  assign pump_switch_enable_out = st_q.sw_en;
  assign active_out = st_q.active;

endmodule

// file: verif/ldc_chk.sv
// ldc_chk: port assertions for the led dimming control block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module ldc_chk #(
  parameter int unsigned NUM_CH = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // status inputs
  input wire logic undervoltage_in,
  input wire logic overvoltage_in,
  input wire logic over_temp_in,
  input wire logic [NUM_CH-1:0] led_open_in,
  // outputs watched
  input wire logic active_out,
  input wire logic [NUM_CH-1:0] led_channel_enable_out,
  input wire logic current_set_pin_enable_out,
  input wire logic [2:0] gain_level_out,
  input wire logic [1:0] pump_mode_out,
  input wire logic pump_switch_enable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////
  // shutdown and fault behaviour
  AST_SHDN_HIZ: assert property (
    !active_out |-> !(|led_channel_enable_out)
      && !current_set_pin_enable_out) else $error("driven in shutdown");
  AST_UV_OFF: assert property (
    undervoltage_in [*8] |=> !active_out) else $error("active in uv");
  AST_OT_OFF: assert property (
    over_temp_in [*8] |=> !active_out) else $error("active when hot");
  ////////////////////////////////////////////////////////////////////////
  // pump mode sequencing
  AST_IDLE_1X: assert property (
    pump_mode_out == ldc_pkg::PUMP_1X |-> !pump_switch_enable_out)
    else $error("switching in 1x");
  AST_OV_1X: assert property (
    overvoltage_in [*8] |=> pump_mode_out == ldc_pkg::PUMP_1X)
    else $error("pump not reset on overvoltage");
  AST_OPEN_1X: assert property (
    (&led_open_in) [*8] |=> pump_mode_out == ldc_pkg::PUMP_1X)
    else $error("pump not 1x with all open");
  AST_STEP_ORDER: assert property (
    $changed(pump_mode_out) && pump_mode_out != ldc_pkg::PUMP_1X
      |-> pump_mode_out == $past(pump_mode_out) + 2'h1)
    else $error("pump mode out of order");
  ////////////////////////////////////////////////////////////////////////
  // dimming level sequence
  AST_GAIN_RANGE: assert property (
    gain_level_out <= ldc_pkg::LEVEL_LAST) else $error("gain out of range");
  AST_GAIN_WRAP: assert property (
    $changed(gain_level_out) && active_out && $past(active_out)
      |-> gain_level_out == (($past(gain_level_out) == ldc_pkg::LEVEL_LAST)
        ? ldc_pkg::LEVEL_FULL : $past(gain_level_out) + 3'h1))
    else $error("gain step wrong");
endmodule
bind ldc_top ldc_chk #(.NUM_CH(NUM_CH)) u_chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .undervoltage_in(undervoltage_in),
  .overvoltage_in(overvoltage_in), .over_temp_in(over_temp_in),
  .led_open_in(led_open_in), .active_out(active_out),
  .led_channel_enable_out(led_channel_enable_out),
  .current_set_pin_enable_out(current_set_pin_enable_out),
  .gain_level_out(gain_level_out), .pump_mode_out(pump_mode_out),
  .pump_switch_enable_out(pump_switch_enable_out));

// file: verif/ldc_host.sv
// ldc_host: host model driving the enable and dimming pin
// assumes the caller's clock; levels change 2 ns after a rising edge
`timescale 1ns/1ns
module ldc_host (
  // clock
  input wire logic clk_in,
  // enable and dimming pin
  output logic pin_out
);
  initial pin_out = 1'b0;
  // hold one level for n cycles
  task automatic drive(logic lvl, int n);
    @(posedge clk_in);
    #2;
    pin_out = lvl;
    repeat (n - 1) @(posedge clk_in);
    // return off the edge so callers never sample or drive on it
    #2;
  endtask
  // low pulse then the high gap before the next one
  task automatic pulse(int low);
    drive(1'b0, low);
    drive(1'b1, 20);
  endtask
  // leave shutdown, stay high before any dimming
  task automatic wake();
    drive(1'b1, 260);
  endtask
endmodule

// file: verif/testbench.sv
// testbench: self-checking bench for ldc_top
// assumes short sleep and step counts: SLEEP_CYC 200, STEP_CYC 50
`timescale 1ns/1ns
module testbench;
  typedef struct {int low; logic [2:0] lvl;} ldc_row_s;
  logic clk_in, reset_n_in, pin, uv, ov, ot, ok1x;
  logic [2:0] open_ch, low_hr, led_en, gain;
  logic current_set_pin_en, settled, sw_en, active;
  logic [1:0] pump;
  int err_total = 0;
  int checked = 0;
  // low width beside the gain level expected after the pulse
  ldc_row_s rows [8] = '{'{10, 3'h1}, '{5, 3'h2}, '{150, 3'h3},
    '{3, 3'h3}, '{10, 3'h4}, '{10, 3'h5}, '{10, 3'h0}, '{10, 3'h1}};
  ////////////////////////////////////////////////////////////////////////
  ldc_host host (.clk_in(clk_in), .pin_out(pin));
  ldc_top #(.SLEEP_CYC(200), .STEP_CYC(50), .NUM_CH(3)) DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .enable_dim_input_in(pin),
    .undervoltage_in(uv), .overvoltage_in(ov), .over_temp_in(ot),
    .unity_mode_ok_in(ok1x), .led_open_in(open_ch),
    .led_low_headroom_in(low_hr), .led_channel_enable_out(led_en),
    .current_set_pin_enable_out(current_set_pin_en), .gain_level_out(gain),
    .current_settled_out(settled), .pump_mode_out(pump),
    .pump_switch_enable_out(sw_en), .active_out(active));
  ////////////////////////////////////////////////////////////////////////
  // compare tasks, closing task and cycle wait
  task automatic chk(string what, logic [2:0] e, logic [2:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_flag(string what, logic e, logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", what, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    {reset_n_in, uv, ov, ot, ok1x} = 5'h0;
    {open_ch, low_hr} = 6'h0;
    cyc(20);
    reset_n_in = 1'b1;
    cyc(4);
    chk_flag("active", 1'b0, active);
    chk("pump", {1'b0, ldc_pkg::PUMP_1X}, {1'b0, pump});
    host.wake();
    chk_flag("active", 1'b1, active);
    chk("gain", ldc_pkg::LEVEL_FULL, gain);
    chk("led_en", 3'h7, led_en);
    foreach (rows[i]) begin
      host.pulse(rows[i].low);
      chk("gain", rows[i].lvl, gain);
    end
    chk_flag("settled", 1'b0, settled);
    cyc(1000);
    chk_flag("settled", 1'b1, settled);
    host.drive(1'b0, 250);
    chk_flag("active", 1'b0, active);
    chk("led_en", 3'h0, led_en);
    chk_flag("current_set_pin_en", 1'b0, current_set_pin_en);
    host.wake();
    low_hr = 3'h1;
    cyc(40);
    chk("pump", 3'h0, {1'b0, pump});
    for (int m = 1; m < 4; m++) begin
      cyc(m == 1 ? 30 : 55);
      chk("pump", m[2:0], {1'b0, pump});
      chk_flag("sw_en", 1'b1, sw_en);
    end
    low_hr = 3'h0;
    ok1x = 1'b1;
    cyc(20);
    chk("pump", 3'h0, {1'b0, pump});
    chk_flag("sw_en", 1'b0, sw_en);
    ok1x = 1'b0;
    open_ch = 3'h1;
    low_hr = 3'h1;
    cyc(120);
    chk("pump", 3'h0, {1'b0, pump});
    open_ch = 3'h7;
    low_hr = 3'h7;
    cyc(120);
    chk("pump", 3'h0, {1'b0, pump});
    open_ch = 3'h0;
    cyc(70);
    chk("pump", 3'h1, {1'b0, pump});
    ov = 1'b1;
    cyc(20);
    chk("pump", 3'h0, {1'b0, pump});
    {ov, low_hr} = 4'h0;
    for (int f = 0; f < 2; f++) begin
      if (f == 0) uv = 1'b1;
      else ot = 1'b1;
      cyc(20);
      chk_flag("active", 1'b0, active);
      chk("led_en", 3'h0, led_en);
      {uv, ot} = 2'h0;
      host.drive(1'b0, 250);
      host.wake();
      chk_flag("active", 1'b1, active);
    end
    finish_test();
  end
endmodule
